// ---- hw/ops_selector.v ----
// What this block does
// - pair working and protect ports by number
// - 1+1 needs same card type and ports
// - protection enabled per port, rest unprotected
// - nonrevertive keeps traffic on protect
// - revertive returns traffic when working recovers
// - new group defaults nonrevertive unidirectional
// - refuse protect port as timing reference
// - timing follows working switch to protect
// - optimized: traffic moves primary to secondary
// - optimized: roles swap, no switch back
// - optimized refuses Manual, no revert option
// - optimized needs equal port counts
// - Manual only when destination below degrade
// - Force overrides degrade, not protect fail; code lets optimized groups force onto a failed protect line
// - Lockout over Force over Manual
// - Lockout on 1+1 protect blocks transfer
// - working lock on blocks transfer
// - 1:1 has lock on and switch only
// - 1:1 protect covers whole card; code only refuses mixing 1:1 and 1+1 groups, any port subset allowed
// - ports outside groups never switch
// Purpose: protection-switch selector for four port pairs of two cards
// Assumes: apb master, line conditions synchronous to core_clk
// Notes:   port n of working card pairs with port n of protect card
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "ops_regs.vh"
module ops_selector (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // apb
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output wire [31:0] prdata,
  // card identity from the shelf
  input  wire [7:0]  work_card_type,
  input  wire [3:0]  work_card_ports,
  input  wire [4:0]  work_card_slot,
  input  wire [7:0]  prot_card_type,
  input  wire [3:0]  prot_card_ports,
  input  wire [4:0]  prot_card_slot,
  // line condition monitors
  input  wire [3:0]  work_signal_fail_flag,
  input  wire [3:0]  work_signal_degrade_flag,
  input  wire [3:0]  prot_signal_fail_flag,
  input  wire [3:0]  prot_signal_degrade_flag,
  // traffic selector
  output wire [3:0]  sel_protect,
  output reg  [3:0]  timing_ref
);
  localparam NP = `OPS_NPORT;
  wire        wr_en;
  wire [11:0] addr;
  wire [31:0] wdata;
  reg  [31:0] rdata;
  reg         hit;
  reg  [3:0]  grp_en_reg;
  reg  [3:0]  revert_reg;
  reg  [3:0]  optim_reg;
  reg  [3:0]  one1_reg;
  reg  [2:0]  err_reg;
  reg  [3:0]  timing_req_reg;
  reg         timing_use_prot_reg;
  reg  [3:0]  cmd_stb;
  reg  [2:0]  cmd_code_reg;
  reg         cmd_prot_reg;
  wire [3:0]  lockout;
  wire [3:0]  lockon;
  wire [7:0]  cmd_level;
  wire [3:0]  cmd_bad;
  wire [3:0]  switched;
  ops_apb_slave u_apb (
    .core_clk (core_clk),
    .rst      (rst),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .prdata   (prdata),
    .wr_en    (wr_en),
    .rd_en    (),
    .addr     (addr),
    .wdata    (wdata),
    .rdata    (rdata),
    .hit      (hit)
  );
  // card compatibility for forming a group
  wire same_card  = (work_card_slot == prot_card_slot);
  wire type_ok    = (work_card_type == prot_card_type);
  wire ports_ok   = (work_card_ports == prot_card_ports);
  wire [3:0] g_en = wdata[`OPS_G_EN_LSB +: 4];
  wire [3:0] g_op = wdata[`OPS_G_OPTIM_LSB +: 4];
  wire [3:0] g_11 = wdata[`OPS_G_ONE1_LSB +: 4];
  wire grp_refuse = ~ports_ok | same_card | ((|(g_en & ~g_op)) & ~type_ok);
  wire grp_11_bad = (|(g_en & g_11)) & (g_en != g_11);
  wire grp_wr     = wr_en & (addr == `OPS_OFF_GROUP);
  wire cmd_wr     = wr_en & (addr == `OPS_OFF_CMD);
  wire tim_wr     = wr_en & (addr == `OPS_OFF_TIMING);
  wire [1:0] cmd_port = wdata[5:4];
  wire tim_bad    = wdata[4] & grp_en_reg[wdata[1:0]] & ~one1_reg[wdata[1:0]];
  always @* begin
    hit   = 1'b1;
    rdata = 32'h0000_0000;
    if (addr == `OPS_OFF_GROUP) begin
      rdata = {16'h0000, one1_reg, optim_reg, revert_reg, grp_en_reg};
    end else if (addr == `OPS_OFF_CARD) begin
      rdata = {29'h0000_0000, ports_ok, type_ok, same_card};
    end else if (addr == `OPS_OFF_CMD) begin
      rdata = {24'h000000, cmd_prot_reg, 3'h0, 1'b0, cmd_code_reg};
    end else if (addr == `OPS_OFF_STATUS) begin
      rdata = {12'h000, cmd_level, lockon, lockout, sel_protect};
    end else if (addr == `OPS_OFF_TIMING) begin
      rdata = {24'h000000, timing_ref, 3'h0, timing_use_prot_reg};
    end else if (addr == `OPS_OFF_ERR) begin
      rdata = {29'h0000_0000, err_reg};
    end else begin
      hit = 1'b0;
    end
  end
  always @(posedge core_clk) begin
    if (rst) begin
      grp_en_reg          <= 4'h0;
      revert_reg          <= 4'h0;
      optim_reg           <= 4'h0;
      one1_reg            <= 4'h0;
      err_reg             <= `OPS_ERR_NONE;
      timing_req_reg      <= 4'h1;
      timing_use_prot_reg <= 1'b0;
      cmd_stb             <= 4'h0;
      cmd_code_reg        <= `OPS_CMD_CLEAR;
      cmd_prot_reg        <= 1'b0;
    end else begin
      cmd_stb <= 4'h0;
      if (grp_wr) begin
        if (grp_refuse | grp_11_bad) begin
          err_reg <= `OPS_ERR_CARD;
        end else begin
          grp_en_reg <= g_en;
          optim_reg  <= g_op;
          one1_reg   <= g_11;
          // new groups start nonrevertive
          revert_reg <= wdata[`OPS_G_REVERT_LSB +: 4] & g_en & ~g_op & grp_en_reg;
          err_reg    <= `OPS_ERR_NONE;
        end
      end else if (cmd_wr) begin
        cmd_code_reg       <= wdata[2:0];
        cmd_prot_reg       <= wdata[7];
        cmd_stb[cmd_port]  <= 1'b1;
        err_reg            <= `OPS_ERR_NONE;
      end else if (tim_wr) begin
        if (tim_bad) begin
          err_reg <= `OPS_ERR_TIMING;
        end else begin
          timing_req_reg      <= 4'h1 << wdata[1:0];
          timing_use_prot_reg <= 1'b0;
          err_reg             <= `OPS_ERR_NONE;
        end
      end else if (|(cmd_stb & cmd_bad)) begin
        err_reg <= `OPS_ERR_CMD;
      end
      if (|(timing_req_reg & switched & ~sel_protect & ~one1_reg) && !tim_wr) begin
        timing_use_prot_reg <= 1'b1;
      end
    end
  end
  // timing reference output, one-hot port, bit set means that port's line
  always @(posedge core_clk) begin
    if (rst) begin
      timing_ref <= 4'h0;
    end else begin
      timing_ref <= timing_use_prot_reg ? timing_req_reg : 4'h0;
    end
  end
  genvar i;
  generate
    for (i = 0; i < NP; i = i + 1) begin : g_port
      ops_port_sel u_sel (
        .core_clk    (core_clk),
        .rst         (rst),
        .grp_en      (grp_en_reg[i]),
        .revert      (revert_reg[i]),
        .optim       (optim_reg[i]),
        .one1        (one1_reg[i]),
        .work_sf     (work_signal_fail_flag[i]),
        .work_sd     (work_signal_degrade_flag[i]),
        .prot_sf     (prot_signal_fail_flag[i]),
        .prot_sd     (prot_signal_degrade_flag[i]),
        .cmd_stb     (cmd_stb[i]),
        .cmd_code    (cmd_code_reg),
        .cmd_to_prot (cmd_prot_reg),
        .sel_prot    (sel_protect[i]),
        .lockout     (lockout[i]),
        .lockon      (lockon[i]),
        .cmd_level   (cmd_level[2*i +: 2]),
        .cmd_bad     (cmd_bad[i]),
        .switched    (switched[i])
      );
    end
  endgenerate
endmodule
`default_nettype wire

// ---- hw/ops_regs.vh ----
// Purpose: constants for the protection-switch selector
// Assumes: apb, 32-bit data, one word per register
// Notes:   offsets are byte addresses
`ifndef OPS_REGS_VH
`define OPS_REGS_VH
`define OPS_NPORT          4
`define OPS_OFF_GROUP      12'h000
`define OPS_OFF_CARD       12'h004
`define OPS_OFF_CMD        12'h008
`define OPS_OFF_STATUS     12'h00c
`define OPS_OFF_TIMING     12'h010
`define OPS_OFF_ERR        12'h014
// group register fields
`define OPS_G_EN_LSB       0
`define OPS_G_REVERT_LSB   4
`define OPS_G_OPTIM_LSB    8
`define OPS_G_ONE1_LSB     12
// command codes
`define OPS_CMD_CLEAR      3'h0
`define OPS_CMD_MANUAL     3'h1
`define OPS_CMD_FORCE      3'h2
`define OPS_CMD_LOCKOUT    3'h3
`define OPS_CMD_LOCKON     3'h4
`define OPS_CMD_SWITCH     3'h5
// error codes
`define OPS_ERR_NONE       3'h0
`define OPS_ERR_CARD       3'h1
`define OPS_ERR_CMD        3'h2
`define OPS_ERR_TIMING     3'h3
`endif

// ---- hw/ops_apb_slave.v ----
// Purpose: apb slave front end, one wait-free access
// Assumes: apb3 master keeps request stable until pready
// Notes:   pulses wr_en / rd_en in the access cycle
`timescale 1ns/1ns
`default_nettype none
module ops_apb_slave (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // apb
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  // register side
  output wire        wr_en,
  output wire        rd_en,
  output wire [11:0] addr,
  output wire [31:0] wdata,
  input  wire [31:0] rdata,
  input  wire        hit
);
  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign addr    = paddr;
  assign wdata   = pwdata;
  assign pslverr = psel & penable & ~hit;
  // read data captured in setup so it is valid in access cycle
  always @(posedge core_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= hit ? rdata : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// ---- hw/ops_port_sel.v ----
// Purpose: selector for one working/protect port pair
// Assumes: condition inputs synchronous to core_clk
// Notes:   sel_prot high means traffic taken from protect line
`timescale 1ns/1ns
`default_nettype none
`include "ops_regs.vh"
module ops_port_sel (
  // clock and reset
  input  wire       core_clk,
  input  wire       rst,
  // configuration
  input  wire       grp_en,
  input  wire       revert,
  input  wire       optim,
  input  wire       one1,
  // line conditions
  input  wire       work_sf,
  input  wire       work_sd,
  input  wire       prot_sf,
  input  wire       prot_sd,
  // commands
  input  wire       cmd_stb,
  input  wire [2:0] cmd_code,
  input  wire       cmd_to_prot,
  // status
  output reg        sel_prot,
  output reg        lockout,
  output reg        lockon,
  output reg  [1:0] cmd_level,
  output wire       cmd_bad,
  output wire       switched
);
  localparam LV_NONE = 2'h0;
  localparam LV_MAN  = 2'h1;
  localparam LV_FRC  = 2'h2;
  reg        sel_next;
  wire       is_lockout = (cmd_code == `OPS_CMD_LOCKOUT);
  wire       is_lockon  = (cmd_code == `OPS_CMD_LOCKON);
  wire       is_force   = (cmd_code == `OPS_CMD_FORCE);
  wire       is_manual  = (cmd_code == `OPS_CMD_MANUAL);
  wire       is_switch  = (cmd_code == `OPS_CMD_SWITCH);
  // lockout only on 1+1 protect side, lock on only working side in 1+1
  wire       bad_lo  = is_lockout & (one1 | ~cmd_to_prot);
  wire       bad_lon = is_lockon & ~one1 & cmd_to_prot;
  wire       bad_fm  = (is_force | is_manual) & one1;
  wire       bad_sw  = is_switch & ~one1;
  wire       bad_opt = is_manual & optim;
  assign cmd_bad = cmd_stb & (~grp_en | bad_lo | bad_lon | bad_fm | bad_sw | bad_opt);
  wire       cmd_ok  = cmd_stb & ~cmd_bad;
  wire       src_sf  = sel_prot ? prot_sf : work_sf;
  wire       dst_sf  = sel_prot ? work_sf : prot_sf;
  wire       dst_sd  = sel_prot ? work_sd : prot_sd;
  wire       blocked = lockout | lockon;
  assign switched = (sel_next != sel_prot);
  always @* begin
    sel_next = sel_prot;
    if (~grp_en) begin
      sel_next = 1'b0;
    end else if (cmd_ok & (is_force | is_switch)) begin
      if (cmd_to_prot != sel_prot && !(blocked && cmd_to_prot) && !(cmd_to_prot && prot_sf && ~optim)) begin
        sel_next = cmd_to_prot;
      end
    end else if (cmd_ok & is_manual & (cmd_level != LV_FRC)) begin
      if (cmd_to_prot != sel_prot && !(blocked && cmd_to_prot) && !dst_sd && !dst_sf) begin
        sel_next = cmd_to_prot;
      end
    end else if (cmd_level == LV_NONE) begin
      if (src_sf && !dst_sf && !(blocked && !sel_prot)) begin
        sel_next = ~sel_prot;
      end else if (revert && !optim && sel_prot && !work_sf && !work_sd && !prot_sf) begin
        sel_next = 1'b0;
      end
    end
    if (sel_next && blocked) begin
      sel_next = 1'b0;
    end
  end
  always @(posedge core_clk) begin
    if (rst) begin
      sel_prot  <= 1'b0;
      lockout   <= 1'b0;
      lockon    <= 1'b0;
      cmd_level <= LV_NONE;
    end else begin
      sel_prot <= sel_next;
      if (~grp_en) begin
        lockout   <= 1'b0;
        lockon    <= 1'b0;
        cmd_level <= LV_NONE;
      end else if (cmd_ok) begin
        if (cmd_code == `OPS_CMD_CLEAR) begin
          lockout   <= 1'b0;
          lockon    <= 1'b0;
          cmd_level <= LV_NONE;
        end else if (is_lockout) begin
          lockout <= 1'b1;
        end else if (is_lockon) begin
          lockon <= 1'b1;
        end else if (is_force) begin
          cmd_level <= LV_FRC;
        end else if (is_manual && cmd_level != LV_FRC) begin
          cmd_level <= LV_MAN;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- bench/ops_selector_chk.sv ----
// Purpose: port checks of the protection-switch selector
// Assumes: apb master holds each request until pready
// Notes:   all checks except reset_clear_a idle while rst is high
`timescale 1ns/1ns
`default_nettype none
module ops_selector_chk (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // lines and selector
  input wire logic [3:0]  prot_signal_fail_flag,
  input wire logic [3:0]  sel_protect,
  input wire logic [3:0]  timing_ref
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  wire mapped = (paddr[1:0] == 2'h0) && (paddr <= 12'h014);

  pready_high_a: assert property (pready) else $error("pready low");
  err_access_a: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
  err_decode_a: assert property (psel && penable |-> pslverr == !mapped) else $error("pslverr wrong for address");
  err_zero_a: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  reset_clear_a: assert property (disable iff (1'b0) rst |=> sel_protect == 4'h0 && timing_ref == 4'h0)
    else $error("outputs not cleared by reset");
  timing_one_a: assert property ($onehot0(timing_ref)) else $error("timing reference not one-hot");
  for (genvar i = 0; i < 4; i++) begin : g_port
    prot_clean_a: assert property ($rose(sel_protect[i]) |-> !$past(prot_signal_fail_flag[i]))
      else $error("switch onto failed protect line");
    timing_follow_a: assert property ($rose(timing_ref[i]) |-> $past(sel_protect[i]))
      else $error("timing moved without traffic switch");
  end
endmodule
`default_nettype wire

// ---- bench/ops_line_mon.sv ----
// Purpose: line condition monitor model
// Assumes: cond packs work fail, work degrade, prot fail, prot degrade
// Notes:   one cycle of filtering, active high levels
`timescale 1ns/1ns
`default_nettype none
module ops_line_mon (
  // clock
  input  wire logic        core_clk,
  // requested conditions
  input  wire logic [15:0] cond,
  // flags to the selector
  output wire logic [3:0]  work_sf,
  output wire logic [3:0]  work_sd,
  output wire logic [3:0]  prot_sf,
  output wire logic [3:0]  prot_sd
);
  logic [15:0] flag_reg = 16'h0000;
  always @(posedge core_clk) begin
    flag_reg <= cond;
  end
  assign {prot_sd, prot_sf, work_sd, work_sf} = flag_reg;
endmodule
`default_nettype wire

// ---- bench/ops_selector_test.sv ----
// Purpose: self-checking bench of the protection-switch selector
// Assumes: zero-wait apb slave, conditions through the monitor model
// Notes:   reads queue value and mask, a monitor compares
`timescale 1ns/1ns
`default_nettype none
module ops_selector_test;
  logic        core_clk, rst, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  wire         pready, pslverr;
  wire  [31:0] prdata;
  logic [7:0]  prot_card_type;
  logic [3:0]  prot_card_ports;
  logic [4:0]  prot_card_slot;
  logic [15:0] cond;
  wire  [3:0]  wsf, wsd, psf, psd, sel_protect, timing_ref;
  logic [32:0] eq[$], mq[$], e, m, seen;
  int          miscompares, n_tests, i, r;

  ops_line_mon ops_line_mon_inst (.core_clk(core_clk), .cond(cond), .work_sf(wsf), .work_sd(wsd),
    .prot_sf(psf), .prot_sd(psd));
  ops_selector ops_selector_inst (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .work_card_type(8'h21),
    .work_card_ports(4'h4), .work_card_slot(5'h02), .prot_card_type(prot_card_type),
    .prot_card_ports(prot_card_ports), .prot_card_slot(prot_card_slot), .work_signal_fail_flag(wsf),
    .work_signal_degrade_flag(wsd), .prot_signal_fail_flag(psf), .prot_signal_degrade_flag(psd),
    .sel_protect(sel_protect), .timing_ref(timing_ref));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) begin
        @(posedge core_clk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
    end
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task rd(input logic [11:0] a, input logic [32:0] ev, input logic [32:0] mv);
    begin
      eq.push_back(ev);
      mq.push_back(mv);
      xfer(1'b0, a, 32'h0);
    end
  endtask

  task settle;
    repeat (4) @(posedge core_clk);
  endtask

  task cmd(input logic [31:0] d);
    begin
      wr(12'h008, d);
      settle;
    end
  endtask

  task cnd(input logic [15:0] c);
    begin
      cond <= c;
      settle;
    end
  endtask

  task er(input logic [2:0] c);
    rd(12'h014, {30'h0, c}, {33{1'b1}});
  endtask

  task st(input logic [32:0] ev, input logic [32:0] mv);
    rd(12'h00c, ev, mv | 33'h100000000);
  endtask

  always @(posedge core_clk) begin
    if (psel && penable && pready && !pwrite && eq.size() > 0) begin
      e = eq.pop_front();
      m = mq.pop_front();
      seen = (paddr == 12'h00c) ? {pslverr, prdata[31:4], sel_protect} : {pslverr, prdata};
      n_tests++;
      if ((seen & m) !== (e & m)) begin
        miscompares++;
        $display("Error read %h expected %h seen %h", paddr, e & m, seen & m);
      end
    end
  end

  task close_out;
    begin
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask

  initial begin
    #100000;
    miscompares++;
    close_out;
  end

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, cond} = '0;
    prot_card_type = 8'h21;
    prot_card_ports = 4'h4;
    prot_card_slot = 5'h03;
    miscompares = 0;
    n_tests = 0;
    r = $urandom(32'h64c0);
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(12'h000, 33'h0, {33{1'b1}});
    rd(12'h004, 33'h6, {33{1'b1}});
    rd(12'h018, 33'h100000000, {33{1'b1}});
    prot_card_slot <= 5'h02;
    wr(12'h000, 32'h1);
    er(3'h1);
    prot_card_slot <= 5'h03;
    prot_card_ports <= 4'h2;
    wr(12'h000, 32'h1);
    er(3'h1);
    wr(12'h000, 32'h101);
    rd(12'h000, 33'h0, {33{1'b1}});
    prot_card_ports <= 4'h4;
    prot_card_type <= 8'h22;
    wr(12'h000, 32'h1);
    er(3'h1);
    prot_card_type <= 8'h21;
    wr(12'h000, 32'h7);
    er(3'h0);
    cmd(32'h05);
    er(3'h2);
    wr(12'h010, 32'h0);
    for (i = 0; i < 8; i++) begin
      r = $urandom;
      cond <= {8'h00, r[0], 3'h0, r[1], 3'h0};
      @(posedge core_clk);
    end
    st(33'h0, 33'h8);
    cnd(16'h0001);
    st(33'h1, 33'h1);
    rd(12'h010, 33'h11, {33{1'b1}});
    cnd(16'h0000);
    st(33'h1, 33'h1);
    wr(12'h010, 32'h11);
    er(3'h3);
    cmd(32'h01);
    st(33'h0, 33'h1);
    wr(12'h000, 32'h27);
    rd(12'h000, 33'h27, {33{1'b1}});
    cnd(16'h0002);
    st(33'h2, 33'h2);
    cnd(16'h0000);
    st(33'h0, 33'h2);
    cnd(16'h4000);
    cmd(32'ha1);
    st(33'h0, 33'h4);
    cnd(16'h0000);
    cmd(32'ha1);
    st(33'h10004, 33'h30004);
    cmd(32'h22);
    st(33'h20000, 33'h30004);
    cmd(32'ha1);
    st(33'h20000, 33'h30004);
    cmd(32'h20);
    cnd(16'h0400);
    cmd(32'ha2);
    st(33'h0, 33'h4);
    cnd(16'h4040);
    cmd(32'ha2);
    st(33'h4, 33'h4);
    cmd(32'ha3);
    cnd(16'h0004);
    st(33'h40, 33'h44);
    cmd(32'h23);
    er(3'h2);
    cmd(32'h14);
    cnd(16'h0002);
    st(33'h200, 33'h202);
    cnd(16'h0000);
    cmd(32'h94);
    er(3'h2);
    wr(12'h000, 32'h1027);
    er(3'h1);
    wr(12'h000, 32'h8af);
    rd(12'h000, 33'h82f, {33{1'b1}});
    cmd(32'hb1);
    er(3'h2);
    cnd(16'h0008);
    st(33'h8, 33'h8);
    cnd(16'h0000);
    st(33'h8, 33'h8);
    wr(12'h000, 32'hf00f);
    rd(12'h000, 33'hf00f, {33{1'b1}});
    cmd(32'h82);
    er(3'h2);
    cmd(32'h85);
    st(33'h1, 33'h1);
    cmd(32'h84);
    st(33'h100, 33'h101);
    close_out;
  end
endmodule

bind ops_selector ops_selector_chk ops_selector_chk_inst (.core_clk(core_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .prot_signal_fail_flag(prot_signal_fail_flag), .sel_protect(sel_protect), .timing_ref(timing_ref));
`default_nettype wire
